// ### inc/dmem_pkg.sv
// constants and types for the data memory space decoder
// assumes one 20 MHz processor clock shared by core and decoder
package dmem_pkg;

   // ==========================================================
   // widths and depths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int REG_AW = 4;
   localparam int IRAM_DEPTH = 256;
   localparam int IRAM_AW = 8;
   localparam int EXPANDED_ONCHIP_RAM_DEPTH = 2048;
   localparam int EXPANDED_ONCHIP_RAM_AW = 11;

   // ==========================================================
   // internal space map
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam logic [7:0] ALL_ONES_MASK = 8'hFF;

   // ==========================================================
   // expanded ram tops per size code, and the hard external floor
   localparam logic [15:0] EXPANDED_ONCHIP_RAM_TOP_256 = 16'h00FF;
   localparam logic [15:0] EXPANDED_ONCHIP_RAM_TOP_512 = 16'h01FF;
   localparam logic [15:0] EXPANDED_ONCHIP_RAM_TOP_1K = 16'h03FF;
   localparam logic [15:0] EXPANDED_ONCHIP_RAM_TOP_2K = 16'h07FF;
   localparam logic [15:0] XMOVE_EXT_FLOOR = 16'h0800;

   // ==========================================================
   // register port offsets
   localparam logic [3:0] REG_BANK_OFS = 4'h0;
   localparam logic [3:0] REG_XCFG_OFS = 4'h1;
   localparam logic [3:0] REG_STAT_OFS = 4'h2;

   // ==========================================================
   // field positions
   localparam int BANK_LOW_POS = 3;
   localparam int BANK_HIGH_POS = 4;
   localparam int EXT_SEL_POS = 1;
   localparam int SIZE_LSB_POS = 2;
   localparam int SIZE_MSB_POS = 3;

   // ==========================================================
   // reset values
   localparam logic [1:0] BANK_RST = 2'h0;
   localparam logic EXT_SEL_RST = 1'b0;
   localparam logic [1:0] SIZE_RST = 2'h3;

   // ==========================================================
   // access modes issued by the core, and decoded targets
   typedef enum logic [2:0] {
      mode_direct,
      mode_indirect,
      mode_register,
      mode_bit,
      mode_xmove_ri,
      mode_xmove_data_pointer
   } access_mode_e;

   typedef enum logic [2:0] {
      tgt_none,
      tgt_lower,
      tgt_upper,
      tgt_sfr,
      tgt_expanded_onchip_ram,
      tgt_ext
   } target_e;

endpackage

// ### src/byte_ram.sv
// single port byte ram with synchronous read and per-bit write mask
// assumes read and write are never requested in the same cycle
`timescale 1ns/1ps

module byte_ram #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // access
   input wire logic i_we,
   input wire logic i_re,
   input wire logic [AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_wmask,
   // read data, valid the cycle after i_re
   output logic [7:0] o_rdata
);

   // ==========================================================
   // storage, deliberately not cleared: contents undefined at power-up
   logic [7:0] mem [DEPTH];
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
      end
   end

   // ==========================================================
   // read port
   always_comb begin
      rdata_next = rdata_reg;
      if (i_re) begin
         rdata_next = mem[i_addr];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

endmodule

// ### src/data_memory_space_decoder.sv
// data memory space decoder: internal ram, banks, bit area, expanded ram
// assumes a core on the same clock issuing one-cycle read or write strobes
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps

module data_memory_space_decoder (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // core access
   input wire logic i_core_rd,
   input wire logic i_core_wr,
   input wire dmem_pkg::access_mode_e i_core_mode,
   input wire logic [dmem_pkg::ADDR_W-1:0] i_core_addr,
   input wire logic [7:0] i_core_wdata,
   // core read answer
   output logic o_core_rvalid,
   output logic [7:0] o_core_rdata,
   output logic o_core_rbit,
   // special function register side
   output logic o_sfr_rd,
   output logic o_sfr_wr,
   output logic o_sfr_bit,
   output logic [7:0] o_sfr_addr,
   output logic [7:0] o_sfr_wdata,
   // off-chip space side
   output logic o_ext_rd,
   output logic o_ext_wr,
   output logic [dmem_pkg::ADDR_W-1:0] o_ext_addr,
   output logic [7:0] o_ext_wdata,
   // register port
   input wire logic [dmem_pkg::REG_AW-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata
);
   import dmem_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [15:0] expanded_onchip_ram_top(input logic [1:0] size);
      logic [15:0] top;
      case (size)
         2'h0: top = EXPANDED_ONCHIP_RAM_TOP_256;
         2'h1: top = EXPANDED_ONCHIP_RAM_TOP_512;
         2'h2: top = EXPANDED_ONCHIP_RAM_TOP_1K;
         default: top = EXPANDED_ONCHIP_RAM_TOP_2K;
      endcase
      return top;
   endfunction

   function automatic logic expanded_onchip_ram_hit(input logic [15:0] addr, input logic ext_sel,
                                     input logic [1:0] size);
      return !ext_sel && (addr <= expanded_onchip_ram_top(size)) && (addr < XMOVE_EXT_FLOOR);
   endfunction

   // ==========================================================
   // control registers
   logic [1:0] bank_reg;
   logic [1:0] bank_next;
   logic ext_space_select_reg;
   logic ext_space_select_next;
   logic [1:0] expanded_onchip_ram_size_field_reg;
   logic [1:0] expanded_onchip_ram_size_field_next;
   logic [7:0] reg_rdata_reg;
   logic [7:0] reg_rdata_next;
   target_e last_tgt_reg;
   target_e last_tgt_next;

   // ==========================================================
   // decode
   target_e tgt;
   logic [IRAM_AW-1:0] iram_addr;
   logic [EXPANDED_ONCHIP_RAM_AW-1:0] expanded_onchip_ram_addr;
   logic [7:0] wmask;
   logic [7:0] wbyte;
   logic [2:0] bit_idx;
   logic access;

   assign access = i_core_rd | i_core_wr;

   always_comb begin
      tgt = tgt_none;
      iram_addr = i_core_addr[7:0];
      expanded_onchip_ram_addr = i_core_addr[EXPANDED_ONCHIP_RAM_AW-1:0];
      wmask = ALL_ONES_MASK;
      wbyte = i_core_wdata;
      bit_idx = i_core_addr[2:0];
      case (i_core_mode)
         mode_direct: begin
            if (!i_core_addr[7]) begin
               tgt = tgt_lower;
            end else begin
               tgt = tgt_sfr;
            end
         end
         mode_indirect: begin
            if (!i_core_addr[7]) begin
               tgt = tgt_lower;
            end else begin
               tgt = tgt_upper;
            end
         end
         mode_register: begin
            tgt = tgt_lower;
            iram_addr = {3'b000, bank_reg, i_core_addr[2:0]};
         end
         mode_bit: begin
            if (!i_core_addr[7]) begin
               tgt = tgt_lower;
               iram_addr = BIT_AREA_BASE | {4'h0, i_core_addr[6:3]};
               wmask = 8'(1 << i_core_addr[2:0]);
               wbyte = {8{i_core_wdata[0]}};
            end else begin
               tgt = tgt_sfr;
            end
         end
         mode_xmove_ri, mode_xmove_data_pointer: begin
            if (expanded_onchip_ram_hit(i_core_addr, ext_space_select_reg, expanded_onchip_ram_size_field_reg)) begin
               tgt = tgt_expanded_onchip_ram;
            end else begin
               tgt = tgt_ext;
            end
         end
         default: tgt = tgt_none;
      endcase
   end

   // ==========================================================
   // storage
   logic iram_we;
   logic iram_re;
   logic expanded_onchip_ram_we;
   logic expanded_onchip_ram_re;
   logic [7:0] iram_q;
   logic [7:0] expanded_onchip_ram_q;

   assign iram_we = i_core_wr && (tgt == tgt_lower || tgt == tgt_upper);
   assign iram_re = i_core_rd && (tgt == tgt_lower || tgt == tgt_upper);
   assign expanded_onchip_ram_we = i_core_wr && (tgt == tgt_expanded_onchip_ram);
   assign expanded_onchip_ram_re = i_core_rd && (tgt == tgt_expanded_onchip_ram);

   // one 256 byte array: lower half shared by direct, indirect, register and bit modes, upper half indirect only
   byte_ram #(
      .DEPTH(IRAM_DEPTH),
      .AW(IRAM_AW)
   ) u_iram (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_we(iram_we),
      .i_re(iram_re),
      .i_addr(iram_addr),
      .i_wdata(wbyte),
      .i_wmask(wmask),
      .o_rdata(iram_q)
   );

   byte_ram #(
      .DEPTH(EXPANDED_ONCHIP_RAM_DEPTH),
      .AW(EXPANDED_ONCHIP_RAM_AW)
   ) u_expanded_onchip_ram (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_we(expanded_onchip_ram_we),
      .i_re(expanded_onchip_ram_re),
      .i_addr(expanded_onchip_ram_addr),
      .i_wdata(wbyte),
      .i_wmask(ALL_ONES_MASK),
      .o_rdata(expanded_onchip_ram_q)
   );

   // ==========================================================
   // read answer and forwarded strobes
   logic rvalid_reg;
   logic rvalid_next;
   target_e rtgt_reg;
   target_e rtgt_next;
   logic [2:0] rbit_idx_reg;
   logic [2:0] rbit_idx_next;
   logic sfr_rd_reg;
   logic sfr_rd_next;
   logic sfr_wr_reg;
   logic sfr_wr_next;
   logic sfr_bit_reg;
   logic sfr_bit_next;
   logic [7:0] sfr_addr_reg;
   logic [7:0] sfr_addr_next;
   logic [7:0] sfr_wdata_reg;
   logic [7:0] sfr_wdata_next;
   logic ext_rd_reg;
   logic ext_rd_next;
   logic ext_wr_reg;
   logic ext_wr_next;
   logic [15:0] ext_addr_reg;
   logic [15:0] ext_addr_next;
   logic [7:0] ext_wdata_reg;
   logic [7:0] ext_wdata_next;

   always_comb begin
      rvalid_next = iram_re | expanded_onchip_ram_re;
      rtgt_next = i_core_rd ? tgt : tgt_none;
      rbit_idx_next = i_core_rd ? bit_idx : rbit_idx_reg;
      // a strobe goes only to the single decoded target
      sfr_rd_next = i_core_rd && (tgt == tgt_sfr);
      sfr_wr_next = i_core_wr && (tgt == tgt_sfr);
      sfr_bit_next = sfr_bit_reg;
      sfr_addr_next = sfr_addr_reg;
      sfr_wdata_next = sfr_wdata_reg;
      if (access && tgt == tgt_sfr) begin
         sfr_bit_next = (i_core_mode == mode_bit);
         sfr_addr_next = i_core_addr[7:0];
         sfr_wdata_next = i_core_wdata;
      end
      ext_rd_next = i_core_rd && (tgt == tgt_ext);
      ext_wr_next = i_core_wr && (tgt == tgt_ext);
      ext_addr_next = ext_addr_reg;
      ext_wdata_next = ext_wdata_reg;
      if (access && tgt == tgt_ext) begin
         ext_addr_next = i_core_addr;
         ext_wdata_next = i_core_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rvalid_reg <= 1'b0;
         rtgt_reg <= tgt_none;
         rbit_idx_reg <= 3'h0;
         sfr_rd_reg <= 1'b0;
         sfr_wr_reg <= 1'b0;
         sfr_bit_reg <= 1'b0;
         sfr_addr_reg <= 8'h00;
         sfr_wdata_reg <= 8'h00;
         ext_rd_reg <= 1'b0;
         ext_wr_reg <= 1'b0;
         ext_addr_reg <= 16'h0000;
         ext_wdata_reg <= 8'h00;
      end else begin
         rvalid_reg <= rvalid_next;
         rtgt_reg <= rtgt_next;
         rbit_idx_reg <= rbit_idx_next;
         sfr_rd_reg <= sfr_rd_next;
         sfr_wr_reg <= sfr_wr_next;
         sfr_bit_reg <= sfr_bit_next;
         sfr_addr_reg <= sfr_addr_next;
         sfr_wdata_reg <= sfr_wdata_next;
         ext_rd_reg <= ext_rd_next;
         ext_wr_reg <= ext_wr_next;
         ext_addr_reg <= ext_addr_next;
         ext_wdata_reg <= ext_wdata_next;
      end
   end

   always_comb begin
      case (rtgt_reg)
         tgt_lower, tgt_upper: o_core_rdata = iram_q;
         tgt_expanded_onchip_ram: o_core_rdata = expanded_onchip_ram_q;
         default: o_core_rdata = 8'h00;
      endcase
   end

   assign o_core_rvalid = rvalid_reg;
   assign o_core_rbit = o_core_rdata[rbit_idx_reg];
   assign o_sfr_rd = sfr_rd_reg;
   assign o_sfr_wr = sfr_wr_reg;
   assign o_sfr_bit = sfr_bit_reg;
   assign o_sfr_addr = sfr_addr_reg;
   assign o_sfr_wdata = sfr_wdata_reg;
   assign o_ext_rd = ext_rd_reg;
   assign o_ext_wr = ext_wr_reg;
   assign o_ext_addr = ext_addr_reg;
   assign o_ext_wdata = ext_wdata_reg;

   // ==========================================================
   // register port
   always_comb begin
      bank_next = bank_reg;
      ext_space_select_next = ext_space_select_reg;
      expanded_onchip_ram_size_field_next = expanded_onchip_ram_size_field_reg;
      last_tgt_next = access ? tgt : last_tgt_reg;
      reg_rdata_next = 8'h00;
      if (i_reg_wr) begin
         case (i_reg_addr)
            REG_BANK_OFS: bank_next = {i_reg_wdata[BANK_HIGH_POS], i_reg_wdata[BANK_LOW_POS]};
            REG_XCFG_OFS: begin
               ext_space_select_next = i_reg_wdata[EXT_SEL_POS];
               expanded_onchip_ram_size_field_next = i_reg_wdata[SIZE_MSB_POS:SIZE_LSB_POS];
            end
            default: bank_next = bank_reg;
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            REG_BANK_OFS: begin
               reg_rdata_next[BANK_HIGH_POS] = bank_reg[1];
               reg_rdata_next[BANK_LOW_POS] = bank_reg[0];
            end
            REG_XCFG_OFS: begin
               reg_rdata_next[EXT_SEL_POS] = ext_space_select_reg;
               reg_rdata_next[SIZE_MSB_POS:SIZE_LSB_POS] = expanded_onchip_ram_size_field_reg;
            end
            REG_STAT_OFS: reg_rdata_next = {5'h00, 3'(last_tgt_reg)};
            default: reg_rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bank_reg <= BANK_RST;
         ext_space_select_reg <= EXT_SEL_RST;
         expanded_onchip_ram_size_field_reg <= SIZE_RST;
         last_tgt_reg <= tgt_none;
         reg_rdata_reg <= 8'h00;
      end else begin
         bank_reg <= bank_next;
         ext_space_select_reg <= ext_space_select_next;
         expanded_onchip_ram_size_field_reg <= expanded_onchip_ram_size_field_next;
         last_tgt_reg <= last_tgt_next;
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   assign o_reg_rdata = reg_rdata_reg;

endmodule

// ### tb/dmem_monitor.sv
// port assertions for the data memory space decoder
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps

module dmem_monitor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // core side
   input wire logic i_core_rd,
   input wire logic i_core_wr,
   input wire dmem_pkg::access_mode_e i_core_mode,
   input wire logic [15:0] i_core_addr,
   input wire logic [7:0] i_core_wdata,
   input wire logic o_core_rvalid,
   // forwarded sides
   input wire logic o_sfr_rd,
   input wire logic o_sfr_wr,
   input wire logic o_sfr_bit,
   input wire logic [7:0] o_sfr_addr,
   input wire logic [7:0] o_sfr_wdata,
   input wire logic o_ext_rd,
   input wire logic o_ext_wr,
   input wire logic [15:0] o_ext_addr,
   input wire logic [7:0] o_ext_wdata
);
   import dmem_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ========
   // routing
   a_lower_reads:
      assert property (i_core_rd && i_core_mode inside {mode_direct, mode_indirect}
         && !i_core_addr[7] |=> o_core_rvalid && !o_sfr_rd) else $error("lower read lost");
   a_upper_indirect:
      assert property (i_core_rd && i_core_mode == mode_indirect && i_core_addr[7]
         |=> o_core_rvalid && !o_sfr_rd) else $error("upper read lost");
   a_direct_to_sfr:
      assert property (i_core_wr && i_core_mode == mode_direct && i_core_addr[7]
         |=> o_sfr_wr && o_sfr_addr == $past(i_core_addr[7:0])
         && o_sfr_wdata == $past(i_core_wdata)) else $error("direct high write not forwarded");
   a_one_target:
      assert property (o_sfr_wr || o_sfr_rd |-> !o_core_rvalid && !o_ext_wr)
         else $error("two targets at once");
   a_bit_high_sfr:
      assert property ((i_core_rd || i_core_wr) && i_core_mode == mode_bit && i_core_addr[7]
         |=> (o_sfr_rd || o_sfr_wr) && o_sfr_bit) else $error("high bit not forwarded");
   a_bank_no_ext:
      assert property (i_core_rd && i_core_mode == mode_register |=> o_core_rvalid && !o_ext_rd)
         else $error("register read lost");
   a_data_pointer_floor:
      assert property (i_core_rd && i_core_mode == mode_xmove_data_pointer && i_core_addr >= 16'h0800
         |=> o_ext_rd && !o_core_rvalid && o_ext_addr == $past(i_core_addr))
         else $error("pointer move above floor stayed inside");
   a_ext_write_data:
      assert property (o_ext_wr |-> $past(i_core_wr) && o_ext_wdata == $past(i_core_wdata))
         else $error("off-chip write without cause");
   // ========
   // coverage
   c_ext_write: cover property (o_ext_wr);
   c_sfr_bit: cover property (o_sfr_wr && o_sfr_bit);
   c_expanded_onchip_ram_read: cover property (i_core_rd && i_core_mode == mode_xmove_ri ##1 o_core_rvalid);
endmodule

// ### tb/core_model.sv
// behavioural core issuing one data access at a time
// assumes the decoder takes strobes on the rising edge
`timescale 1ns/1ps

module core_model (
   // clock
   input wire logic i_clk,
   // access
   output logic o_rd,
   output logic o_wr,
   output dmem_pkg::access_mode_e o_mode,
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata
);
   import dmem_pkg::*;
   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_mode = mode_direct;
      o_addr = 16'h0000;
      o_wdata = 8'h00;
   end
   // ========
   // one access; callers write ram before reading it back
   task automatic xfer(input logic wr, input access_mode_e m, input logic [15:0] a,
         input logic [7:0] d);
      @(posedge i_clk);
      o_rd <= !wr;
      o_wr <= wr;
      o_mode <= m;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      // released lines flip so stale values never look valid
      o_addr <= ~a;
      o_wdata <= ~d;
      #1;
   endtask
endmodule

// ### tb/data_memory_space_decoder_bench.sv
// self-checking bench for the data memory space decoder
// assumes core_model drives the core port, the bench the register port
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module data_memory_space_decoder_bench;
   import dmem_pkg::*;
   logic clk, rst_b, core_rd, core_wr, rvalid, rbit, sfr_rd, sfr_wr, sfr_bit, ext_rd, ext_wr;
   logic reg_wr, reg_rd;
   access_mode_e core_mode;
   logic [15:0] core_addr, ext_addr;
   logic [7:0] core_wdata, rdata, sfr_addr, sfr_wdata, ext_wdata, reg_wdata, reg_rdata;
   logic [3:0] reg_addr;
   int fails = 0;
   int total_checks = 0;

   core_model core_u (.i_clk(clk), .o_rd(core_rd), .o_wr(core_wr), .o_mode(core_mode),
      .o_addr(core_addr), .o_wdata(core_wdata));
   data_memory_space_decoder dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_core_rd(core_rd),
      .i_core_wr(core_wr), .i_core_mode(core_mode), .i_core_addr(core_addr),
      .i_core_wdata(core_wdata), .o_core_rvalid(rvalid), .o_core_rdata(rdata),
      .o_core_rbit(rbit), .o_sfr_rd(sfr_rd), .o_sfr_wr(sfr_wr), .o_sfr_bit(sfr_bit),
      .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata), .o_ext_rd(ext_rd), .o_ext_wr(ext_wr),
      .o_ext_addr(ext_addr), .o_ext_wdata(ext_wdata), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ========
   // register port cycles
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // ========
   // scenarios
   task automatic t_regs();
      logic [7:0] v;
      reg_read(REG_BANK_OFS, v);
      `CHK(v, 8'h00);
      reg_write(4'hF, 8'hFF);
      reg_read(REG_XCFG_OFS, v);
      `CHK(v, 8'h0C);
      $display("test regs done");
   endtask
   task automatic t_lower_upper();
      core_u.xfer(1'b1, mode_direct, 16'h0012, 8'hA5);
      core_u.xfer(1'b0, mode_indirect, 16'h0012, 8'h00);
      `CHK({rvalid, rdata}, 9'h1A5);
      core_u.xfer(1'b1, mode_indirect, 16'h0085, 8'h3C);
      core_u.xfer(1'b1, mode_direct, 16'h0085, 8'h5A);
      `CHK({sfr_wr, sfr_addr, sfr_wdata}, 17'h1855A);
      core_u.xfer(1'b0, mode_indirect, 16'h0085, 8'h00);
      `CHK({rvalid, sfr_rd, rdata}, 10'h23C);
      core_u.xfer(1'b0, mode_direct, 16'h0090, 8'h00);
      `CHK({sfr_rd, rvalid, sfr_addr}, 10'h290);
      $display("test lower_upper done");
   endtask
   task automatic t_banks();
      for (int b = 0; b < 4; b++) begin
         reg_write(REG_BANK_OFS, 8'(b << BANK_LOW_POS));
         core_u.xfer(1'b1, mode_register, 16'h0003, 8'(8'h40 + b));
         core_u.xfer(1'b0, mode_direct, 16'(b * 8 + 3), 8'h00);
         `CHK({rvalid, rdata}, {1'b1, 8'(8'h40 + b)});
         core_u.xfer(1'b0, mode_register, 16'h0003, 8'h00);
         `CHK({rvalid, ext_rd, rdata}, {2'b10, 8'(8'h40 + b)});
      end
      reg_write(REG_BANK_OFS, 8'h00);
      $display("test banks done");
   endtask
   task automatic t_bits();
      core_u.xfer(1'b1, mode_direct, 16'h0021, 8'h00);
      core_u.xfer(1'b1, mode_bit, 16'h000D, 8'h01);
      core_u.xfer(1'b0, mode_direct, 16'h0021, 8'h00);
      `CHK(rdata, 8'h20);
      core_u.xfer(1'b0, mode_bit, 16'h000D, 8'h00);
      `CHK({rvalid, rbit}, 2'b11);
      core_u.xfer(1'b1, mode_bit, 16'h0085, 8'h01);
      `CHK({sfr_wr, sfr_bit}, 2'b11);
      $display("test bits done");
   endtask
   task automatic t_expanded_onchip_ram();
      logic [15:0] top;
      logic [7:0] v;
      for (int s = 0; s < 4; s++) begin
         top = (16'h0100 << s) - 16'h0001;
         reg_write(REG_XCFG_OFS, 8'(s << SIZE_LSB_POS));
         core_u.xfer(1'b1, mode_xmove_ri, top, 8'(8'h90 + s));
         core_u.xfer(1'b0, mode_xmove_data_pointer, top, 8'h00);
         `CHK({rvalid, ext_rd, rdata}, {2'b10, 8'(8'h90 + s)});
         core_u.xfer(1'b1, mode_xmove_ri, top + 16'h0001, 8'h6B);
         `CHK({ext_wr, ext_addr, ext_wdata}, {1'b1, top + 16'h0001, 8'h6B});
      end
      core_u.xfer(1'b0, mode_xmove_ri, 16'h07FF, 8'h00);
      `CHK({rvalid, rdata}, 9'h193);
      core_u.xfer(1'b0, mode_xmove_data_pointer, 16'hFFFF, 8'h00);
      `CHK({ext_rd, rvalid, ext_addr}, 18'h2FFFF);
      reg_write(REG_XCFG_OFS, 8'h0E);
      core_u.xfer(1'b0, mode_xmove_ri, 16'h0000, 8'h00);
      `CHK({ext_rd, rvalid}, 2'b10);
      reg_read(REG_STAT_OFS, v);
      `CHK(v, {5'h00, 3'(tgt_ext)});
      $display("test expanded_onchip_ram done");
   endtask
   // ========
   // verdict
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      // tests need about 110 cycles, so this only catches a hang
      repeat (5000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_lower_upper();
      t_banks();
      t_bits();
      t_expanded_onchip_ram();
      report_and_stop();
   end
endmodule

bind data_memory_space_decoder dmem_monitor mon_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_core_rd(i_core_rd), .i_core_wr(i_core_wr), .i_core_mode(i_core_mode),
   .i_core_addr(i_core_addr), .i_core_wdata(i_core_wdata), .o_core_rvalid(o_core_rvalid),
   .o_sfr_rd(o_sfr_rd), .o_sfr_wr(o_sfr_wr), .o_sfr_bit(o_sfr_bit), .o_sfr_addr(o_sfr_addr),
   .o_sfr_wdata(o_sfr_wdata), .o_ext_rd(o_ext_rd), .o_ext_wr(o_ext_wr),
   .o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata));
